/* File: rtl/ep0_params.svh */
`ifndef EP0_PARAMS_SVH
`define EP0_PARAMS_SVH
// register offsets (byte addresses, indexed window of the controller)
`define EP0_CSR0_ADDR     8'h00
`define EP0_CSR2_ADDR     8'h04
`define EP0_IRQ_STAT_ADDR 8'h08
`define EP0_IRQ_MASK_ADDR 8'h0C
// control/status register 0 fields
`define CSR0_PING_DIS     27
`define CSR0_TGL_WREN     26
`define CSR0_TGL_STATE    25
`define CSR0_FLUSH        24
`define CSR0_SETEND_SVC   23
`define CSR0_RXRDY_SVC    22
`define CSR0_SETEND_FLAG  20
`define CSR0_TX_READY     17
`define CSR0_RX_READY     16
// host-role aliases; the first two share positions with device-role bits
`define CSR0_NAK_TMO      23
`define CSR0_STATUS_STAGE 22
`define CSR0_IN_REQUEST   21
// register 2 fields
`define CSR2_NAK_LIMIT_LSB   24
`define CSR2_SPEED_LSB    22
`define CSR2_RX_BYTE_COUNT_LSB    0
// interrupt status bits
`define IRQ_SETEND        0
`define IRQ_RXRDY         1
`define IRQ_NAKTMO        2
`define IRQ_FLUSHED       3
`define IRQ_BITS          4
`define ZERO32            32'h0000_0000
`endif

/* File: rtl/ep0_pkg.sv */
package ep0_pkg;
   typedef enum logic [1:0] {SPD_RSVD = 2'h0, SPD_HI = 2'h1, SPD_FULL = 2'h2,
                             SPD_LOW = 2'h3} speed_e;
   typedef struct packed {
      logic        ping_disable;
      logic        toggle_write_enable;
      logic        data_toggle_state;
      logic        fifo_flush_request;
      logic        setup_end_flag;
      logic        tx_packet_ready;
      logic        rx_packet_ready;
      logic        nak_timeout_flag;
      logic        status_stage_request;
      logic        in_request;
      logic [4:0]  nak_limit;
      logic [1:0]  speed;
      logic [4:0]  nak_frames;
      logic [3:0]  irq_stat;
      logic [3:0]  irq_mask;
      logic [31:0] rdata;
   } state_s;
endpackage

/* File: rtl/usb_endpoint0_control.sv */
`timescale 1ns/1ps
`include "ep0_params.svh"
module usb_endpoint0_control #(
   parameter int CNT_W = 7
) (
   input  wire logic              CLK_I,
   input  wire logic              RST_I,
   input  wire logic [7:0]        ADDR_I,
   input  wire logic [31:0]       WDATA_I,
   input  wire logic              WR_I,
   input  wire logic              RD_I,
   output logic      [31:0]       RDATA_O,
   output logic                   IRQ_O,
   input  wire logic              HOST_MODE_I,
   input  wire logic              SETUP_END_EVT_I,
   input  wire logic              RX_PKT_EVT_I,
   input  wire logic              TX_DONE_EVT_I,
   input  wire logic              NAK_EVT_I,
   input  wire logic              ACK_EVT_I,
   input  wire logic              FRAME_TICK_I,
   input  wire logic              TOGGLE_UPD_I,
   input  wire logic              TOGGLE_VAL_I,
   input  wire logic [CNT_W-1:0]  FIFO_COUNT_I,
   output logic                   PING_ENABLE_O,
   output logic                   TOGGLE_O,
   output logic                   TOGGLE_LOAD_O,
   output logic                   FIFO_FLUSH_O,
   output logic                   EP_HALT_O,
   output logic                   TX_GO_O,
   output logic                   IN_GO_O,
   output logic                   STATUS_STAGE_O,
   output logic [1:0]             SPEED_O
);
   // elaboration check: the read mux places the count in a seven-bit field
   if (CNT_W != 7)
   begin : g_bad_cnt_w
      $error("rx count must be 7 bits wide");
   end

   ep0_pkg::state_s st_r;
   ep0_pkg::state_s st_nxt;
   logic wr0;
   logic wr2;
   logic wrs;
   logic wrm;
   logic [3:0] ev;

   // decode a single write target
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   assign wr0 = WR_I && hit(ADDR_I, `EP0_CSR0_ADDR);
   assign wr2 = WR_I && hit(ADDR_I, `EP0_CSR2_ADDR);
   assign wrs = WR_I && hit(ADDR_I, `EP0_IRQ_STAT_ADDR);
   assign wrm = WR_I && hit(ADDR_I, `EP0_IRQ_MASK_ADDR);

   // next-state logic for the whole register block
   always_comb
   begin
      st_nxt = st_r;
      // command pulses from the previous cycle have now taken effect
      // self-clear commands
      st_nxt.toggle_write_enable = 1'b0;
      st_nxt.fifo_flush_request = 1'b0;
      if (TOGGLE_UPD_I)
         st_nxt.data_toggle_state = TOGGLE_VAL_I;
      // hardware clears tx ready and the in and status requests; ordered so a software set below beats this clear
      if (TX_DONE_EVT_I)
         st_nxt.tx_packet_ready = 1'b0;
      if (ACK_EVT_I)
      begin
         st_nxt.in_request = 1'b0;
         st_nxt.status_stage_request = 1'b0;
      end
      if (wr0)
      begin
         st_nxt.ping_disable = WDATA_I[`CSR0_PING_DIS];
         st_nxt.toggle_write_enable = WDATA_I[`CSR0_TGL_WREN];
         if (st_r.toggle_write_enable && HOST_MODE_I)
            st_nxt.data_toggle_state = WDATA_I[`CSR0_TGL_STATE];
         if (WDATA_I[`CSR0_FLUSH])
         begin
            st_nxt.fifo_flush_request = 1'b1;
            st_nxt.tx_packet_ready = 1'b0;
            st_nxt.rx_packet_ready = 1'b0;
         end
         if (WDATA_I[`CSR0_TX_READY])
            st_nxt.tx_packet_ready = 1'b1;
         if (HOST_MODE_I)
         begin
            // status stage armed with tx or in request
            if (WDATA_I[`CSR0_STATUS_STAGE])
               st_nxt.status_stage_request = 1'b1;
            if (WDATA_I[`CSR0_IN_REQUEST])
               st_nxt.in_request = 1'b1;
            // software write of zero lets the endpoint continue
            if (!WDATA_I[`CSR0_NAK_TMO])
               st_nxt.nak_timeout_flag = 1'b0;
         end
         else
         begin
            if (WDATA_I[`CSR0_SETEND_SVC])
               st_nxt.setup_end_flag = 1'b0;
            if (WDATA_I[`CSR0_RXRDY_SVC])
               st_nxt.rx_packet_ready = 1'b0;
         end
      end
      // events win over any clear in the same cycle
      if (SETUP_END_EVT_I && !HOST_MODE_I)
         st_nxt.setup_end_flag = 1'b1;
      if (RX_PKT_EVT_I)
         st_nxt.rx_packet_ready = 1'b1;
      if (!HOST_MODE_I || ACK_EVT_I || !(st_r.in_request || st_r.tx_packet_ready))
         st_nxt.nak_frames = 5'h00;
      else if (NAK_EVT_I && FRAME_TICK_I && st_r.nak_frames != 5'h1F)
         st_nxt.nak_frames = st_r.nak_frames + 5'h01;
      // limit reached sets time-out; limit of zero disables it
      if (HOST_MODE_I && NAK_EVT_I && st_r.nak_limit != 5'h00 &&
          st_r.nak_frames >= st_r.nak_limit)
         st_nxt.nak_timeout_flag = 1'b1;
      // speed field stored verbatim, reserved code kept as written
      if (wr2)
      begin
         st_nxt.nak_limit = WDATA_I[`CSR2_NAK_LIMIT_LSB +: 5];
         st_nxt.speed = WDATA_I[`CSR2_SPEED_LSB +: 2];
      end
      // sticky interrupt status, write one to clear, set wins
      ev = {st_nxt.fifo_flush_request, st_nxt.nak_timeout_flag & ~st_r.nak_timeout_flag,
            RX_PKT_EVT_I, SETUP_END_EVT_I & ~HOST_MODE_I};
      if (wrs)
         st_nxt.irq_stat = st_r.irq_stat & ~WDATA_I[`IRQ_BITS-1:0];
      st_nxt.irq_stat = st_nxt.irq_stat | ev;
      if (wrm)
         st_nxt.irq_mask = WDATA_I[`IRQ_BITS-1:0];
      // read data, one cycle after the strobe
      // unimplemented bits zero
      st_nxt.rdata = `ZERO32;
      if (RD_I)
      begin
         unique case (ADDR_I)
            `EP0_CSR0_ADDR:
            begin
               st_nxt.rdata[`CSR0_PING_DIS] = st_r.ping_disable;
               st_nxt.rdata[`CSR0_TGL_WREN] = st_r.toggle_write_enable;
               st_nxt.rdata[`CSR0_TGL_STATE] = st_r.data_toggle_state;
               st_nxt.rdata[`CSR0_FLUSH] = st_r.fifo_flush_request;
               st_nxt.rdata[`CSR0_SETEND_FLAG] = st_r.setup_end_flag;
               st_nxt.rdata[`CSR0_TX_READY] = st_r.tx_packet_ready;
               st_nxt.rdata[`CSR0_RX_READY] = st_r.rx_packet_ready;
               if (HOST_MODE_I)
               begin
                  st_nxt.rdata[`CSR0_NAK_TMO] = st_r.nak_timeout_flag;
                  st_nxt.rdata[`CSR0_STATUS_STAGE] = st_r.status_stage_request;
                  st_nxt.rdata[`CSR0_IN_REQUEST] = st_r.in_request;
               end
            end
            `EP0_CSR2_ADDR:
            begin
               st_nxt.rdata[`CSR2_NAK_LIMIT_LSB +: 5] = st_r.nak_limit;
               st_nxt.rdata[`CSR2_SPEED_LSB +: 2] = st_r.speed;
               // count only valid while rx ready
               if (st_r.rx_packet_ready)
                  st_nxt.rdata[`CSR2_RX_BYTE_COUNT_LSB +: 7] = FIFO_COUNT_I;
            end
            `EP0_IRQ_STAT_ADDR: st_nxt.rdata[`IRQ_BITS-1:0] = st_r.irq_stat;
            `EP0_IRQ_MASK_ADDR: st_nxt.rdata[`IRQ_BITS-1:0] = st_r.irq_mask;
            default: st_nxt.rdata = `ZERO32;
         endcase
      end
   end

   // single register bank
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign RDATA_O = st_r.rdata;
   assign IRQ_O = |(st_r.irq_stat & st_r.irq_mask);
   // ping only when not disabled, host role
   assign PING_ENABLE_O = HOST_MODE_I && !st_r.ping_disable;
   assign TOGGLE_O = st_r.data_toggle_state;
   assign TOGGLE_LOAD_O = st_r.toggle_write_enable;
   // pointer reset pulse to the FIFO
   assign FIFO_FLUSH_O = st_r.fifo_flush_request;
   assign EP_HALT_O = HOST_MODE_I && st_r.nak_timeout_flag;
   assign TX_GO_O = st_r.tx_packet_ready && !EP_HALT_O;
   assign IN_GO_O = HOST_MODE_I && st_r.in_request && !EP_HALT_O;
   assign STATUS_STAGE_O = HOST_MODE_I && st_r.status_stage_request &&
                           (st_r.tx_packet_ready || st_r.in_request);
   assign SPEED_O = st_r.speed;

   property p_flush_self_clear;
      @(posedge CLK_I) disable iff (RST_I)
      FIFO_FLUSH_O |=> !FIFO_FLUSH_O;
   endproperty
   a_flush_self_clear: assert property (p_flush_self_clear)
      else $error("flush did not self clear");

   property p_flush_clears_ready;
      @(posedge CLK_I) disable iff (RST_I)
      (wr0 && WDATA_I[`CSR0_FLUSH] && !WDATA_I[`CSR0_TX_READY] && !RX_PKT_EVT_I)
      |=> FIFO_FLUSH_O && !st_r.rx_packet_ready && !st_r.tx_packet_ready;
   endproperty
   a_flush_clears_ready: assert property (p_flush_clears_ready)
      else $error("flush left a ready flag set");

   property p_tgl_wren_clear;
      @(posedge CLK_I) disable iff (RST_I)
      st_r.toggle_write_enable && !wr0 |=> !st_r.toggle_write_enable;
   endproperty
   a_tgl_wren_clear: assert property (p_tgl_wren_clear)
      else $error("toggle write enable stuck");

   property p_tgl_locked;
      @(posedge CLK_I) disable iff (RST_I)
      wr0 && !st_r.toggle_write_enable && !TOGGLE_UPD_I |=> $stable(TOGGLE_O);
   endproperty
   a_tgl_locked: assert property (p_tgl_locked)
      else $error("toggle changed without enable");

   property p_setend_svc;
      @(posedge CLK_I) disable iff (RST_I)
      wr0 && !HOST_MODE_I && WDATA_I[`CSR0_SETEND_SVC] && !SETUP_END_EVT_I
      |=> !st_r.setup_end_flag;
   endproperty
   a_setend_svc: assert property (p_setend_svc)
      else $error("setup end not cleared");

   property p_rx_svc;
      @(posedge CLK_I) disable iff (RST_I)
      wr0 && !HOST_MODE_I && WDATA_I[`CSR0_RXRDY_SVC] && !RX_PKT_EVT_I
      |=> !st_r.rx_packet_ready;
   endproperty
   a_rx_svc: assert property (p_rx_svc)
      else $error("rx ready not cleared");

   property p_ping;
      @(posedge CLK_I) disable iff (RST_I)
      HOST_MODE_I && st_r.ping_disable |-> !PING_ENABLE_O;
   endproperty
   a_ping: assert property (p_ping)
      else $error("ping issued while disabled");

   property p_halt;
      @(posedge CLK_I) disable iff (RST_I)
      EP_HALT_O |-> !TX_GO_O && !IN_GO_O;
   endproperty
   a_halt: assert property (p_halt)
      else $error("halted endpoint still active");

   property p_rx_byte_count_zero;
      @(posedge CLK_I) disable iff (RST_I)
      RD_I && hit(ADDR_I, `EP0_CSR2_ADDR) && !st_r.rx_packet_ready
      |=> RDATA_O[6:0] == 7'h00 && RDATA_O[21:7] == 15'h0000;
   endproperty
   a_rx_byte_count_zero: assert property (p_rx_byte_count_zero)
      else $error("rx count or reserved bits nonzero");

   property p_speed;
      @(posedge CLK_I) disable iff (RST_I)
      wr2 |=> SPEED_O == $past(WDATA_I[`CSR2_SPEED_LSB +: 2]);
   endproperty
   a_speed: assert property (p_speed)
      else $error("speed field not stored");

   // enable write opens the load window on the next cycle
   property p_tgl_arm;
      @(posedge CLK_I) disable iff (RST_I)
      wr0 && WDATA_I[`CSR0_TGL_WREN] |=> TOGGLE_LOAD_O;
   endproperty
   a_tgl_arm: assert property (p_tgl_arm)
      else $error("toggle load window not opened");

   // a host write inside the window sets the toggle
   sequence s_tgl_load;
      TOGGLE_LOAD_O && wr0 && HOST_MODE_I;
   endsequence
   property p_tgl_load;
      @(posedge CLK_I) disable iff (RST_I)
      s_tgl_load |=> TOGGLE_O == $past(WDATA_I[`CSR0_TGL_STATE]);
   endproperty
   a_tgl_load: assert property (p_tgl_load)
      else $error("toggle not loaded in window");

   // status stage armed together with a data request
   sequence s_stat_arm;
      wr0 && HOST_MODE_I && WDATA_I[`CSR0_STATUS_STAGE] &&
      (WDATA_I[`CSR0_TX_READY] || WDATA_I[`CSR0_IN_REQUEST]);
   endsequence
   property p_stat_arm;
      @(posedge CLK_I) disable iff (RST_I)
      s_stat_arm ##1 HOST_MODE_I |-> STATUS_STAGE_O;
   endproperty
   a_stat_arm: assert property (p_stat_arm)
      else $error("status stage not requested");

   // an acknowledge ends the status stage
   property p_stat_done;
      @(posedge CLK_I) disable iff (RST_I)
      ACK_EVT_I && !wr0 |=> !STATUS_STAGE_O;
   endproperty
   a_stat_done: assert property (p_stat_done)
      else $error("status stage outlived its acknowledge");

   // a halt only follows a NAK, unless the role has just switched to host
   property p_halt_cause;
      @(posedge CLK_I) disable iff (RST_I)
      $rose(EP_HALT_O) && $stable(HOST_MODE_I) |-> $past(NAK_EVT_I);
   endproperty
   a_halt_cause: assert property (p_halt_cause)
      else $error("halt without a NAK");

   // the read port rests at zero between reads
   property p_rdata_idle;
      @(posedge CLK_I) disable iff (RST_I)
      !RD_I |=> RDATA_O == `ZERO32;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside its cycle");

   // device-role service bits never read back as one
   property p_svc_zero;
      @(posedge CLK_I) disable iff (RST_I)
      RD_I && hit(ADDR_I, `EP0_CSR0_ADDR) && !HOST_MODE_I
      |=> !RDATA_O[`CSR0_SETEND_SVC] && !RDATA_O[`CSR0_RXRDY_SVC];
   endproperty
   a_svc_zero: assert property (p_svc_zero)
      else $error("service bit read back as one");

endmodule // usb_endpoint0_control

/* File: bench/ep0_engine_model.sv */
`timescale 1ns/1ps
// far-side packet engine: one-cycle event pulses plus the FIFO byte count
module ep0_engine_model (
   input  wire logic       clk,
   output logic            setup_end_evt,
   output logic            rx_pkt_evt,
   output logic            tx_done_evt,
   output logic            nak_evt,
   output logic            ack_evt,
   output logic            frame_tick,
   output logic            toggle_upd,
   output logic            toggle_val,
   output logic [6:0]      fifo_count
);
   initial
   begin
      {toggle_upd, toggle_val, setup_end_evt, rx_pkt_evt} = 4'h0;
      {tx_done_evt, nak_evt, ack_evt, frame_tick} = 4'h0;
      fifo_count = 7'h00;
   end
   // events are single-cycle pulses; the count holds until the next pulse
   task automatic pulse(input logic [7:0] m, input logic [6:0] cnt);
      @(posedge clk);
      {toggle_upd, toggle_val, setup_end_evt, rx_pkt_evt} <= m[7:4];
      {tx_done_evt, nak_evt, ack_evt, frame_tick} <= m[3:0];
      fifo_count <= cnt;
      @(posedge clk);
      {toggle_upd, toggle_val, setup_end_evt, rx_pkt_evt} <= 4'h0;
      {tx_done_evt, nak_evt, ack_evt, frame_tick} <= 4'h0;
      #1;
   endtask
endmodule // ep0_engine_model

/* File: bench/tb_usb_endpoint0_control.sv */
`timescale 1ns/1ps
module tb_usb_endpoint0_control;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        host = 1'b0;
   logic [31:0] rdata;
   logic        irq, ping_en, tgl, tgl_ld, flush, halt, tx_go, in_go, stat_stg;
   logic [1:0]  speed;
   logic        se, rxe, txe, nak, ack, tick, tu, tv;
   logic [6:0]  cnt;
   int          mismatches = 0;
   int          n_compared = 0;
   int          i;
   always #50 clk = ~clk;
   ep0_engine_model eng (.clk(clk), .setup_end_evt(se), .rx_pkt_evt(rxe),
      .tx_done_evt(txe), .nak_evt(nak), .ack_evt(ack), .frame_tick(tick),
      .toggle_upd(tu), .toggle_val(tv), .fifo_count(cnt));
   usb_endpoint0_control dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .HOST_MODE_I(host),
      .SETUP_END_EVT_I(se), .RX_PKT_EVT_I(rxe), .TX_DONE_EVT_I(txe), .NAK_EVT_I(nak),
      .ACK_EVT_I(ack), .FRAME_TICK_I(tick), .TOGGLE_UPD_I(tu), .TOGGLE_VAL_I(tv),
      .FIFO_COUNT_I(cnt), .PING_ENABLE_O(ping_en), .TOGGLE_O(tgl),
      .TOGGLE_LOAD_O(tgl_ld), .FIFO_FLUSH_O(flush), .EP_HALT_O(halt),
      .TX_GO_O(tx_go), .IN_GO_O(in_go), .STATUS_STAGE_O(stat_stg), .SPEED_O(speed));
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", what, exp, got);
         mismatches++;
      end
   endtask
   // one-cycle write strobe; the leading edge wait keeps strobes from colliding
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   // two back-to-back writes; the strobe stays high across both
   task automatic wr_pair(input logic [7:0] a, input logic [31:0] d0, input logic [31:0] d1);
      @(posedge clk);
      addr <= a;
      wdata <= d0;
      wr <= 1'b1;
      @(posedge clk);
      wdata <= d1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(what, exp, rdata);
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd_chk("csr0 reset", 8'h00, 32'h0000_0000);
      rd_chk("unmapped", 8'h10, 32'h0000_0000);
      // speed codes, with ones written to every unimplemented position
      for (i = 0; i < 4; i++)
      begin
         wr_reg(8'h04, 32'hE03F_FFFF | (32'(i) << 22));
         chk("speed pin", 32'(i), {30'h0, speed});
         rd_chk("csr2", 8'h04, 32'(i) << 22);
      end
      $display("test speed done");
      eng.pulse(8'h10, 7'h2A);
      rd_chk("rx ready", 8'h00, 32'h0001_0000);
      rd_chk("rx count", 8'h04, 32'h00C0_002A);
      wr_reg(8'h00, 32'h0040_0000);
      rd_chk("rx serviced", 8'h00, 32'h0000_0000);
      eng.pulse(8'h20, 7'h00);
      rd_chk("setup end", 8'h00, 32'h0010_0000);
      wr_reg(8'h00, 32'h0080_0000);
      rd_chk("setup serviced", 8'h00, 32'h0000_0000);
      rd_chk("irq status", 8'h08, 32'h0000_0003);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr_reg(8'h0C, 32'h0000_0001);
      chk("irq raised", 32'h1, {31'h0, irq});
      wr_reg(8'h08, 32'h0000_0003);
      chk("irq cleared", 32'h0, {31'h0, irq});
      $display("test device service done");
      // flush while a transmit packet is pending
      wr_reg(8'h00, 32'h0002_0000);
      rd_chk("tx ready", 8'h00, 32'h0002_0000);
      wr_reg(8'h00, 32'h0100_0000);
      chk("flush pulse", 32'h1, {31'h0, flush});
      rd_chk("flushed", 8'h00, 32'h0000_0000);
      $display("test flush done");
      @(posedge clk);
      host <= 1'b1;
      wr_reg(8'h00, 32'h0200_0000);
      chk("toggle locked", 32'h0, {31'h0, tgl});
      // the load window is one cycle wide, so the value write follows with no gap
      wr_pair(8'h00, 32'h0400_0000, 32'h0200_0000);
      chk("toggle loaded", 32'h1, {31'h0, tgl});
      chk("load window closed", 32'h0, {31'h0, tgl_ld});
      rd_chk("toggle read", 8'h00, 32'h0200_0000);
      eng.pulse(8'h80, 7'h00);
      chk("toggle engine", 32'h0, {31'h0, tgl});
      wr_reg(8'h00, 32'h0062_0000);
      chk("status stage", 32'h1, {31'h0, stat_stg});
      chk("in go", 32'h1, {31'h0, in_go});
      eng.pulse(8'h02, 7'h00);
      chk("status done", 32'h0, {31'h0, stat_stg});
      chk("in done", 32'h0, {31'h0, in_go});
      chk("ping on", 32'h1, {31'h0, ping_en});
      wr_reg(8'h00, 32'h0800_0000);
      chk("ping off", 32'h0, {31'h0, ping_en});
      $display("test host control done");
      // NAK run against a limit of two frames
      wr_reg(8'h04, 32'h0240_0000);
      eng.pulse(8'h05, 7'h00);
      chk("no early halt", 32'h0, {31'h0, halt});
      i = 0;
      while (halt !== 1'b1 && i < 8)
      begin
         eng.pulse(8'h05, 7'h00);
         i++;
      end
      chk("nak halt", 32'h1, {31'h0, halt});
      chk("nak frames", 32'h2, 32'(i));
      chk("tx held", 32'h0, {31'h0, tx_go});
      rd_chk("irq nak", 8'h08, 32'h0000_000C);
      wr_reg(8'h00, 32'h0000_0000);
      chk("halt cleared", 32'h0, {31'h0, halt});
      chk("tx resumed", 32'h1, {31'h0, tx_go});
      $display("test nak timeout done");
      finish_test();
   end
   // hang guard
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      finish_test();
   end
endmodule // tb_usb_endpoint0_control
